/* logic/brut_pkg.sv */
// constants and state types of the baud rate utility timer
package brut_pkg;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned PRE_W            = 2;
  localparam int unsigned CNT_W            = 8;
  // control register field positions
  localparam int unsigned CTL_RUN_BIT      = 7;
  localparam int unsigned CTL_IRQEN_BIT    = 2;
  localparam int unsigned CTL_PRE_LSB      = 0;
  // reset values
  localparam logic [7:0]  CTL_RESET        = 8'h00;
  localparam logic [7:0]  RELOAD_RESET     = 8'h00;
  localparam logic [1:0]  PRE_RESET        = 2'h0;
  localparam logic [7:0]  CNT_RESET        = 8'h00;
  // mclk is the oscillator; one machine state is two oscillator periods,
  // one timer count is two machine states
  localparam int unsigned OSC_PER_STATE    = 2;
  localparam int unsigned STATES_PER_COUNT = 2;
  localparam int unsigned CLK_PER_COUNT    = OSC_PER_STATE * STATES_PER_COUNT;
  localparam int unsigned DIV_W            = 2;
  localparam logic [1:0]  DIV_LAST         = 2'(CLK_PER_COUNT - 1);

  typedef struct packed {
    logic [1:0] div;
    logic       tick;
  } brut_div_s;

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] reload;
    logic [1:0] pre;
    logic [7:0] cnt;
    logic       sclk;
    logic       flag;
    logic       expiry;
    logic       irq;
  } brut_state_s;
endpackage

/* logic/brut_tick_if.sv */
// count tick carried from the clock divider to the timer core
`timescale 1ns/1ns
interface brut_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

/* logic/brut_divider.sv */
// divider that turns the oscillator clock into one count tick per two machine states
`timescale 1ns/1ns
module brut_divider (
  input  logic  mclk,
  input  logic  rst_n,
  brut_tick_if.src tk
);
  brut_pkg::brut_div_s st;
  brut_pkg::brut_div_s next_st;

  always_comb begin
    next_st      = st;
    next_st.tick = (st.div == brut_pkg::DIV_LAST);
    if (st.div == brut_pkg::DIV_LAST) begin
      next_st.div = '0;
    end else begin
      next_st.div = st.div + 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tk.tick = st.tick;
endmodule

/* logic/brut_timer.sv */
// baud rate utility timer: prescaler, down-counter, bit clock halving and expiry flag
//
// Function
// - counts only on an internal tick every two machine states; no external clock
// - free running; new counter reload values take effect only when both pass zero together, new prescale bits at each prescaler zero
// - control bit 7 set runs the timer; cleared halts counting
// - 2-bit prescaler reloads from control bits 1:0; 8-bit counter from reload register
// - on passing zero together, prescaler and counter each reload from their own value
// - each expiry toggles a halving stage giving the 50 percent serial bit clock
// - asynchronous baud is one over 32 times (pr+1)(tr+1) machine states
// - isosynchronous and shift baud is one over 4 times (pr+1)(tr+1) states
// - every expiry sets the expiry flag; serial interrupt only when enable is set
// - serial soft reset leaves timer, flag and interrupt enable untouched
`timescale 1ns/1ns
module brut_timer (
  input  logic       mclk,
  input  logic       rst_n,
  input  logic       ctl_wr,
  input  logic       reload_wr,
  input  logic [7:0] wdata,
  input  logic       flag_clr,
  input  logic       serial_soft_reset,
  output logic [7:0] ctl_rdata,
  output logic [7:0] reload_rdata,
  output logic [7:0] count_rdata,
  output logic [1:0] prescale_rdata,
  output logic       timer_expiry_flag,
  output logic       timer_expiry,
  output logic       shared_serial_interrupt,
  output logic       sclk
);
  // ==========================================================
  // count tick
  brut_tick_if tk ();

  brut_divider brut_divider_i (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tk    (tk)
  );

  // ==========================================================
  // timer state
  brut_pkg::brut_state_s st;
  brut_pkg::brut_state_s next_st;
  logic                  run;
  logic                  irq_en;
  logic [1:0]            prescale_reload_value;
  logic                  pass_zero;

  assign run                   = st.ctl[brut_pkg::CTL_RUN_BIT];
  assign irq_en                = st.ctl[brut_pkg::CTL_IRQEN_BIT];
  assign prescale_reload_value = st.ctl[brut_pkg::CTL_PRE_LSB +: brut_pkg::PRE_W];
  // both stages pass zero together on this tick
  assign pass_zero = tk.tick && run && (st.pre == 2'h0) && (st.cnt == 8'h00);

  always_comb begin
    next_st        = st;
    next_st.expiry = 1'b0;
    next_st.irq    = 1'b0;
    if (ctl_wr) begin
      next_st.ctl = wdata;
    end
    if (reload_wr) begin
      next_st.reload = wdata;
    end
    if (tk.tick && run) begin
      if (pass_zero) begin
        next_st.pre    = prescale_reload_value;
        next_st.cnt    = st.reload;
        next_st.expiry = 1'b1;
        next_st.irq    = irq_en;
        next_st.sclk   = ~st.sclk;
      end else if (st.pre == 2'h0) begin
        next_st.pre = prescale_reload_value;
        next_st.cnt = st.cnt - 8'h01;
      end else begin
        next_st.pre = st.pre - 2'h1;
      end
    end
    // set wins over clear
    if (flag_clr) begin
      next_st.flag = 1'b0;
    end
    if (pass_zero) begin
      next_st.flag = 1'b1;
    end
  end

  // serial_soft_reset is deliberately not a term here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{ctl: brut_pkg::CTL_RESET, reload: brut_pkg::RELOAD_RESET,
               pre: brut_pkg::PRE_RESET, cnt: brut_pkg::CNT_RESET,
               sclk: 1'b0, flag: 1'b0, expiry: 1'b0, irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign ctl_rdata               = st.ctl;
  assign reload_rdata            = st.reload;
  assign count_rdata             = st.cnt;
  assign prescale_rdata          = st.pre;
  assign timer_expiry_flag       = st.flag;
  assign timer_expiry            = st.expiry;
  assign shared_serial_interrupt = st.irq;
  assign sclk                    = st.sclk;

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // count path
  a_tick_spacing: assert property (tk.tick |=> !tk.tick [*3])
    else $error("count tick closer than four clocks");

  a_tick_gate: assert property (!tk.tick |=> $stable(st.cnt) && $stable(st.pre))
    else $error("timer moved between count ticks");

  a_halt_hold: assert property ($past(!run) |-> $stable(st.cnt) && $stable(st.pre))
    else $error("timer moved while halted");

  a_halt_quiet: assert property (!run |=> !timer_expiry)
    else $error("expiry while halted");

  a_pre_dec: assert property (
      tk.tick && run && st.pre != 2'h0
      |=> st.pre == $past(st.pre) - 2'h1 && st.cnt == $past(st.cnt))
    else $error("prescaler did not decrement alone");

  a_cnt_dec: assert property (
      tk.tick && run && st.pre == 2'h0 && st.cnt != 8'h00
      |=> st.cnt == $past(st.cnt) - 8'h01 && st.pre == $past(prescale_reload_value))
    else $error("counter step or prescaler reload wrong");

  a_reload_load: assert property (
      timer_expiry
      |-> st.cnt == $past(st.reload) && st.pre == $past(prescale_reload_value))
    else $error("reload values not taken at expiry");

  a_expiry_zero: assert property (
      timer_expiry |-> $past(st.pre) == 2'h0 && $past(st.cnt) == 8'h00)
    else $error("expiry without both stages at zero");

  a_reload_late: assert property (
      reload_wr && !pass_zero
      |=> st.cnt == $past(st.cnt) || st.cnt == $past(st.cnt) - 8'h01)
    else $error("reload write disturbed counter");

  a_period_gate: assert property (timer_expiry |-> $past(tk.tick) && $past(run))
    else $error("expiry without count tick");

  a_expiry_space: assert property (timer_expiry |=> !timer_expiry [*3])
    else $error("expiries closer than one count tick");

  // ==========================================================
  // bit clock
  a_sclk_toggle: assert property (timer_expiry |-> sclk != $past(sclk))
    else $error("bit clock not toggled at expiry");

  a_sclk_hold: assert property (!timer_expiry |-> $stable(sclk))
    else $error("bit clock moved without expiry");

  a_pass_expiry: assert property (pass_zero |=> timer_expiry)
    else $error("pass through zero gave no expiry");

  // ==========================================================
  // flag and interrupt
  a_flag_set: assert property (timer_expiry |-> timer_expiry_flag)
    else $error("expiry did not set flag");

  a_flag_rise: assert property ($rose(timer_expiry_flag) |-> timer_expiry)
    else $error("flag rose without expiry");

  a_flag_sticky: assert property (timer_expiry_flag && !flag_clr |=> timer_expiry_flag)
    else $error("flag dropped without clear");

  a_flag_clear: assert property (flag_clr && !pass_zero |=> !timer_expiry_flag)
    else $error("flag clear not taken");

  a_irq_gate: assert property (shared_serial_interrupt == (timer_expiry && $past(irq_en)))
    else $error("interrupt not gated by enable");

  a_irq_expiry: assert property (shared_serial_interrupt |-> timer_expiry)
    else $error("interrupt request without expiry");

  a_irq_off: assert property (timer_expiry && !$past(irq_en) |-> !shared_serial_interrupt)
    else $error("interrupt request with enable clear");

  // ==========================================================
  // registers and soft reset
  a_ctl_write: assert property (ctl_wr |=> ctl_rdata == $past(wdata))
    else $error("control write not stored");

  a_reload_write: assert property (reload_wr |=> reload_rdata == $past(wdata))
    else $error("reload write not stored");

  a_ctl_hold: assert property (!ctl_wr |=> $stable(ctl_rdata))
    else $error("control changed without write");

  a_reload_hold: assert property (!reload_wr |=> $stable(reload_rdata))
    else $error("reload changed without write");

  a_soft_reset: assert property (
      serial_soft_reset && timer_expiry_flag && !flag_clr && !ctl_wr
      |=> timer_expiry_flag && $stable(st.ctl))
    else $error("soft reset touched timer");

  a_soft_count: assert property (
      serial_soft_reset && tk.tick && run && st.pre != 2'h0
      |=> st.pre == $past(st.pre) - 2'h1)
    else $error("soft reset stopped the prescaler");

  // ==========================================================
  // covers
  c_expiry_irq: cover property (timer_expiry && shared_serial_interrupt);
  c_expiry_noirq: cover property (timer_expiry && !shared_serial_interrupt);
  c_set_clear: cover property (pass_zero && flag_clr);
  c_two_expiry: cover property (timer_expiry ##[1:64] timer_expiry);
  c_halted: cover property (!run && tk.tick);
endmodule

/* dv/brut_serial_model.sv */
// far-side serial logic model: counts set requests for the shared interrupt flag
`timescale 1ns/1ns
module brut_serial_model (
  input  logic mclk,
  input  logic rst_n,
  input  logic set_irq,
  output int   irq_cnt
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) irq_cnt <= 0;
    else if (set_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end
endmodule

/* dv/brut_timer_tb_top.sv */
// self-checking bench for the baud rate utility timer
`timescale 1ns/1ns
module brut_timer_tb_top;
  logic       mclk, rst_n, ctl_wr, reload_wr, flag_clr, soft_rst;
  logic [7:0] wdata, ctl_q, rel_q, cnt_q;
  logic [1:0] pre_q;
  logic       flag, exp_p, irq_p, sclk, s0;
  logic [9:0] snap;
  int         n_mismatch = 0, cmp_count = 0, n, irqs, i0;
  int         prs[3] = '{0, 3, 3};
  int         trs[3] = '{0, 2, 255};
  brut_timer brut_timer_i (.mclk(mclk), .rst_n(rst_n), .ctl_wr(ctl_wr),
    .reload_wr(reload_wr), .wdata(wdata), .flag_clr(flag_clr),
    .serial_soft_reset(soft_rst), .ctl_rdata(ctl_q), .reload_rdata(rel_q),
    .count_rdata(cnt_q), .prescale_rdata(pre_q), .timer_expiry_flag(flag),
    .timer_expiry(exp_p), .shared_serial_interrupt(irq_p), .sclk(sclk));
  brut_serial_model brut_serial_model_i (.mclk(mclk), .rst_n(rst_n),
    .set_irq(irq_p), .irq_cnt(irqs));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one-cycle strobe; sel high writes control, low writes the reload
  task automatic wr(input logic sel, input logic [7:0] d);
    @(negedge mclk);
    ctl_wr = sel;
    reload_wr = !sel;
    wdata = d;
    @(negedge mclk);
    ctl_wr = 1'b0;
    reload_wr = 1'b0;
  endtask
  // cycles to the next expiry pulse land in n
  task automatic wait_exp;
    n = 0;
    s0 = sclk;
    do begin
      @(negedge mclk);
      n++;
    end while (exp_p !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      n_mismatch++;
      tally_and_finish();
    end else begin
      chk(sclk, !s0);
      chk(flag, 1'b1);
    end
  endtask
  // ==================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    ctl_wr = 1'b0;
    reload_wr = 1'b0;
    wdata = 8'h00;
    flag_clr = 1'b0;
    soft_rst = 1'b0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    chk({ctl_q, rel_q, cnt_q, pre_q, flag, sclk}, 32'h0);
    wr(1'b0, 8'h02);
    wr(1'b1, 8'h81);
    chk({ctl_q, rel_q}, 32'h8102);
    wait_exp;
    wait_exp;
    chk(n, brut_pkg::CLK_PER_COUNT * 6);
    chk(irqs, 0);
    wr(1'b0, 8'h04);
    wait_exp;
    chk(n, brut_pkg::CLK_PER_COUNT * 6 - 2);
    wait_exp;
    chk(n, brut_pkg::CLK_PER_COUNT * 10);
    soft_rst = 1'b1;
    flag_clr = 1'b1;
    @(negedge mclk);
    flag_clr = 1'b0;
    @(negedge mclk);
    chk(flag, 1'b0);
    wait_exp;
    chk(n, brut_pkg::CLK_PER_COUNT * 10 - 2);
    soft_rst = 1'b0;
    foreach (prs[k]) begin
      wr(1'b0, trs[k][7:0]);
      wr(1'b1, {6'h21, prs[k][1:0]});
      wait_exp;
      i0 = irqs;
      wait_exp;
      chk(n, brut_pkg::CLK_PER_COUNT * (prs[k] + 1) * (trs[k] + 1));
      chk(irqs - i0, 1);
      if (k == 0) begin
        // clear lands on the same edge as the next expiry
        repeat (3) @(negedge mclk);
        flag_clr = 1'b1;
        @(negedge mclk);
        flag_clr = 1'b0;
        chk(flag, 1'b1);
      end
    end
    wr(1'b1, 8'h04);
    snap = {cnt_q, pre_q};
    repeat (40) @(negedge mclk);
    chk({cnt_q, pre_q}, snap);
    tally_and_finish();
  end
endmodule
